// [ovm_overflow_unit.v]
// Overview of operation
// - Overflow with stop switch on and clearing not inhibited halts unless next instruction tests overflow.
// - Overflow just before an overflow jump never halts; the jump executes.
// - While clearing is inhibited, overflow stays recorded; testing it does not clear it.
// - Divide with potential overflow is skipped; dividend shifts right one place.
// - Rounded multiply adds low-half top bit into high half; low half kept.
// - Product negative when operand signs differ, positive when they match.
// - Unrounded multiply leaves equal sign bits in both product halves.
// - Remainder always carries the dividend's sign.
// - Negative quotients come out in one's complement, except exact negative-dividend cases.
// - Exact negative-dividend divide leaves minus divisor magnitude as remainder.
// - In that correction the quotient drops by one in its lowest bit.
// - Exact divide, both negative: quotient one less than the true value.
// - Exact divide, negative by positive: quotient becomes true two's complement.
// - Exact divide, positive dividend: zero remainder, quotient normal form.
// - Indicator cleared before arithmetic or shift unless inhibited; set on overflow.
// - Overflow jump branches on one; no-overflow jump branches on zero.
// - Inhibit clears indicator and blocks clearing; only release unblocks.
// - Add overflow is carry into sign differing from carry out of sign.
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "ovm_consts.vh"

module ovm_overflow_unit #(
    parameter W = 48
) (
    input wire clk,                 // System clock, 50 MHz
    input wire rst,                 // Synchronous reset, active high
    input wire wb_cyc_i,            // Wishbone cycle
    input wire wb_stb_i,            // Wishbone strobe
    input wire wb_we_i,             // Wishbone write enable
    input wire [7:0] wb_adr_i,      // Wishbone byte address
    input wire [3:0] wb_sel_i,      // Wishbone byte lanes
    input wire [31:0] wb_dat_i,     // Wishbone write data
    output reg [31:0] wb_dat_o,     // Wishbone read data
    output reg wb_ack_o,            // Wishbone acknowledge
    input wire ovf_stop_sw,         // Console overflow stop switch
    output reg ovf_lamp_o,          // Overflow indicator lamp
    output reg halt_o,              // Machine stopped on overflow
    output reg irq_o                // Level interrupt
);
    localparam HW = W - 32;
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_STOP = 3'b100;

    // Two's complement magnitude; minus one gives the top bit alone
    function [W-1:0] fmag;
        input [W-1:0] v;
        begin
            fmag = v[W-1] ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    // Byte-lane merge of a write into a 32-bit word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    reg [2:0] state_q;
    reg [W-1:0] a_q;
    reg [W-1:0] q_q;
    reg [W-1:0] d_q;
    reg [`OVM_OP_W-1:0] cmd_q;
    reg ind_q;
    reg inh_q;
    reg pend_q;
    reg jump_q;
    reg sgn_q;
    reg dvd_neg_q;
    reg md_start_q;
    reg [`OVM_EV_W-1:0] int_stat_q;
    reg [`OVM_EV_W-1:0] int_mask_q;
    reg [`OVM_EV_W-1:0] int_stat_d;

    wire md_done;
    wire [2*W-1:0] md_prod;
    wire [W-1:0] md_quo;
    wire [W:0] md_rem;

    // Bus request decode; a write acts once, on the edge raising ack
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_go = req & wb_we_i;
    wire idle = state_q == ST_IDLE;
    wire [`OVM_OP_W-1:0] op = wb_dat_i[`OVM_OP_W-1:0];
    wire cmd_wr = wr_go & (wb_adr_i == `OVM_ADR_CMD) & wb_sel_i[0];
    wire is_jmp = (op == `OVM_OP_JOVF) | (op == `OVM_OP_JNOVF);
    wire is_long = (op == `OVM_OP_MUL) | (op == `OVM_OP_MULR);
    wire is_div = op == `OVM_OP_DIV;
    wire is_addsub = (op == `OVM_OP_ADD) | (op == `OVM_OP_SUB);
    wire is_arith = is_addsub | is_long | is_div | (op == `OVM_OP_SHR);
    wire not_resume = op != `OVM_OP_RESUME;
    // A pending stop lets only an overflow or no-overflow jump through
    wire exec = cmd_wr & idle & not_resume & (~pend_q | is_jmp);
    wire stop_now = cmd_wr & idle & not_resume & pend_q & ~is_jmp;
    wire resume = cmd_wr & (state_q == ST_STOP) & ~not_resume;

    // Add/subtract with separate carries into and out of the sign bit
    wire sub = op == `OVM_OP_SUB;
    wire [W-1:0] opnd = sub ? ~d_q : d_q;
    wire [W-1:0] low_s = {1'b0, a_q[W-2:0]} + {1'b0, opnd[W-2:0]} +
        {{(W-1){1'b0}}, sub};
    wire [1:0] top_s = {1'b0, a_q[W-1]} + {1'b0, opnd[W-1]} +
        {1'b0, low_s[W-1]};
    wire [W-1:0] sum = {top_s[0], low_s[W-2:0]};
    wire add_ovf = low_s[W-1] ^ top_s[1];

    // Potential divide overflow: dividend above divisor in magnitude, or equal and non-negative
    wire [W-1:0] mag_a = fmag(a_q);
    wire [W-1:0] mag_d = fmag(d_q);
    wire pot = (mag_a > mag_d) | ((mag_a == mag_d) & ~a_q[W-1]);

    // Signed double-length product from the unsigned magnitude
    wire [2*W-1:0] pneg = ~md_prod + {{(2*W-1){1'b0}}, 1'b1};
    wire [2*W-1:0] pv = sgn_q ? pneg : md_prod;
    wire [W-1:0] mul_a = pv[2*W-2:W-1];
    wire [W-1:0] mul_q = {pv[2*W-2], pv[W-2:0]};
    wire [W-1:0] mul_ar = mul_a + {{(W-1){1'b0}}, pv[W-2]};
    wire mul_ovf = md_prod[2*W-2] & ~sgn_q;
    wire rnd_ovf = ~mul_a[W-1] & mul_ar[W-1];
    wire rounded = cmd_q == `OVM_OP_MULR;
    wire md_is_div = cmd_q == `OVM_OP_DIV;

    // Quotient and remainder fix-ups for signs and exact division
    wire [W-1:0] r_m = md_rem[W-1:0];
    wire exact = r_m == {W{1'b0}};
    wire fix = exact & dvd_neg_q;
    wire [W-1:0] q_adj = fix ? md_quo - {{(W-1){1'b0}}, 1'b1} : md_quo;
    // Complementing the decremented magnitude yields true two's complement
    wire [W-1:0] div_q = sgn_q ? ~q_adj : q_adj;
    wire [W-1:0] r_neg = ~r_m + {{(W-1){1'b0}}, 1'b1};
    wire [W-1:0] d_neg = ~mag_d + {{(W-1){1'b0}}, 1'b1};
    wire [W-1:0] div_r = exact ? (dvd_neg_q ? d_neg : {W{1'b0}}) :
        (dvd_neg_q ? r_neg : r_m);

    // Overflow events from immediate ops and from long-op completion
    wire evt = (exec & is_addsub & add_ovf) | (exec & is_div & pot) |
        (md_done & ~md_is_div & (mul_ovf | (rounded & rnd_ovf)));
    wire clr = exec & is_arith & ~inh_q;
    wire ind_d = (ind_q & ~clr & ~(exec & (op == `OVM_OP_INHIBIT))) | evt;
    wire op_done = (exec & ~is_long & ~(is_div & ~pot)) | md_done;
    wire [`OVM_EV_W-1:0] ev = {op_done, stop_now, evt};
    wire int_w = wr_go & (wb_adr_i == `OVM_ADR_INT_STAT) & wb_sel_i[0];

    // High words merge at bus width, then are cut to the field width
    wire [31:0] a_hi_m = merge({{(32-HW){1'b0}}, a_q[W-1:32]},
        wb_dat_i, wb_sel_i);
    wire [31:0] q_hi_m = merge({{(32-HW){1'b0}}, q_q[W-1:32]},
        wb_dat_i, wb_sel_i);
    wire [31:0] d_hi_m = merge({{(32-HW){1'b0}}, d_q[W-1:32]},
        wb_dat_i, wb_sel_i);

    // Sticky interrupt status, a new event wins over write-one-to-clear
    always @* begin
        int_stat_d = int_stat_q;
        if (int_w) begin
            int_stat_d = int_stat_d & ~wb_dat_i[`OVM_EV_W-1:0];
        end
        int_stat_d = int_stat_d | ev;
    end

    ovm_muldiv_core #(.W(W)) ovm_muldiv_core_inst (
        .clk(clk),
        .rst(rst),
        .start(md_start_q),
        .op_div(md_is_div),
        .mag_x(mag_a),
        .mag_y(mag_d),
        .done_q(md_done),
        .prod_q(md_prod),
        .quo_q(md_quo),
        .rem_q(md_rem)
    );

    // Overflow indicator, inhibit, pending stop and sequencing
    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            ind_q <= 1'b0;
            inh_q <= 1'b0;
            pend_q <= 1'b0;
            jump_q <= 1'b0;
            sgn_q <= 1'b0;
            dvd_neg_q <= 1'b0;
            md_start_q <= 1'b0;
            cmd_q <= `OVM_OP_NOP;
        end else begin
            md_start_q <= 1'b0;
            // Set wins over the automatic clear in the same cycle
            ind_q <= ind_d;
            // Stop only considered while clearing is not inhibited
            if (evt & ~inh_q & ovf_stop_sw) begin
                pend_q <= 1'b1;
            end else if ((exec & is_jmp) | stop_now) begin
                pend_q <= 1'b0;
            end
            if (exec) begin
                cmd_q <= op;
            end
            if (exec & (op == `OVM_OP_INHIBIT)) begin
                inh_q <= 1'b1;
            end else if (exec & (op == `OVM_OP_RELEASE)) begin
                inh_q <= 1'b0;
            end
            if (exec & (op == `OVM_OP_JOVF)) begin
                jump_q <= ind_q;
            end else if (exec & (op == `OVM_OP_JNOVF)) begin
                jump_q <= ~ind_q;
            end
            case (state_q)
                ST_IDLE: begin
                    if (stop_now) begin
                        state_q <= ST_STOP;
                    end else if (exec & (is_long | (is_div & ~pot))) begin
                        sgn_q <= a_q[W-1] ^ d_q[W-1];
                        dvd_neg_q <= a_q[W-1];
                        md_start_q <= 1'b1;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (md_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_STOP: begin
                    // Operator advance; the refused instruction is dropped
                    if (resume) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Accumulator, low-half and operand registers
    always @(posedge clk) begin
        if (rst) begin
            a_q <= {W{1'b0}};
            q_q <= {W{1'b0}};
            d_q <= {W{1'b0}};
        end else if (md_done) begin
            if (md_is_div) begin
                a_q <= div_r;
                q_q <= div_q;
            end else begin
                // Rounding touches only the high half
                a_q <= rounded ? mul_ar : mul_a;
                q_q <= mul_q;
            end
        end else if (exec & is_addsub) begin
            a_q <= sum;
        end else if (exec & (op == `OVM_OP_SHR)) begin
            a_q <= {a_q[W-1], a_q[W-1:1]};
        end else if (exec & is_div & pot) begin
            // Repeating the divide then works on the halved dividend
            a_q <= {a_q[W-1], a_q[W-1:1]};
            q_q <= {W{1'b0}};
        end else if (wr_go & idle) begin
            case (wb_adr_i)
                `OVM_ADR_A_LO: a_q[31:0] <= merge(a_q[31:0], wb_dat_i,
                    wb_sel_i);
                `OVM_ADR_A_HI: a_q[W-1:32] <= a_hi_m[HW-1:0];
                `OVM_ADR_Q_LO: q_q[31:0] <= merge(q_q[31:0], wb_dat_i,
                    wb_sel_i);
                `OVM_ADR_Q_HI: q_q[W-1:32] <= q_hi_m[HW-1:0];
                `OVM_ADR_D_LO: d_q[31:0] <= merge(d_q[31:0], wb_dat_i,
                    wb_sel_i);
                `OVM_ADR_D_HI: d_q[W-1:32] <= d_hi_m[HW-1:0];
                default: begin
                end
            endcase
        end
    end

    // Bus answer, interrupt registers and registered outputs
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `OVM_RST_DATA;
            int_stat_q <= `OVM_RST_MASK;
            int_mask_q <= `OVM_RST_MASK;
            irq_o <= 1'b0;
            ovf_lamp_o <= 1'b0;
            halt_o <= 1'b0;
        end else begin
            // Every address answers in one cycle; unmapped reads are zero
            wb_ack_o <= req;
            wb_dat_o <= `OVM_RST_DATA;
            case (wb_adr_i)
                `OVM_ADR_A_LO: wb_dat_o <= a_q[31:0];
                `OVM_ADR_A_HI: wb_dat_o <= {{(32-HW){1'b0}}, a_q[W-1:32]};
                `OVM_ADR_Q_LO: wb_dat_o <= q_q[31:0];
                `OVM_ADR_Q_HI: wb_dat_o <= {{(32-HW){1'b0}}, q_q[W-1:32]};
                `OVM_ADR_D_LO: wb_dat_o <= d_q[31:0];
                `OVM_ADR_D_HI: wb_dat_o <= {{(32-HW){1'b0}}, d_q[W-1:32]};
                `OVM_ADR_CMD: wb_dat_o <= {{(32-`OVM_OP_W){1'b0}}, cmd_q};
                `OVM_ADR_STATUS: wb_dat_o <= {{(32-`OVM_ST_W){1'b0}},
                    jump_q, state_q == ST_WAIT, state_q == ST_STOP,
                    pend_q, inh_q, ind_q};
                `OVM_ADR_INT_STAT: wb_dat_o <= {{(32-`OVM_EV_W){1'b0}},
                    int_stat_q};
                `OVM_ADR_INT_MASK: wb_dat_o <= {{(32-`OVM_EV_W){1'b0}},
                    int_mask_q};
                default: wb_dat_o <= `OVM_RST_DATA;
            endcase
            if (wr_go & (wb_adr_i == `OVM_ADR_INT_MASK) & wb_sel_i[0]) begin
                int_mask_q <= wb_dat_i[`OVM_EV_W-1:0];
            end
            int_stat_q <= int_stat_d;
            irq_o <= |(int_stat_d & int_mask_q);
            // Lamp follows the flag's next value, inhibit clear included
            ovf_lamp_o <= ind_d;
            halt_o <= (state_q == ST_STOP) ? ~resume : stop_now;
        end
    end
endmodule

// [ovm_consts.vh]
`ifndef OVM_CONSTS_VH
`define OVM_CONSTS_VH

// Register byte offsets on the Wishbone slave
`define OVM_ADR_A_LO 8'h00
`define OVM_ADR_A_HI 8'h04
`define OVM_ADR_Q_LO 8'h08
`define OVM_ADR_Q_HI 8'h0c
`define OVM_ADR_D_LO 8'h10
`define OVM_ADR_D_HI 8'h14
`define OVM_ADR_CMD 8'h18
`define OVM_ADR_STATUS 8'h1c
`define OVM_ADR_INT_STAT 8'h20
`define OVM_ADR_INT_MASK 8'h24

// Instruction codes written to the command register
`define OVM_OP_W 4
`define OVM_OP_NOP 4'h0
`define OVM_OP_ADD 4'h1
`define OVM_OP_SUB 4'h2
`define OVM_OP_SHR 4'h3
`define OVM_OP_MUL 4'h4
`define OVM_OP_MULR 4'h5
`define OVM_OP_DIV 4'h6
`define OVM_OP_JOVF 4'h7
`define OVM_OP_JNOVF 4'h8
`define OVM_OP_INHIBIT 4'h9
`define OVM_OP_RELEASE 4'ha
`define OVM_OP_RESUME 4'hb

// Status register bit positions
`define OVM_ST_W 6
`define OVM_ST_IND 0
`define OVM_ST_INH 1
`define OVM_ST_PEND 2
`define OVM_ST_HALT 3
`define OVM_ST_BUSY 4
`define OVM_ST_JUMP 5

// Interrupt event bit positions
`define OVM_EV_W 3
`define OVM_EV_OVF 0
`define OVM_EV_HALT 1
`define OVM_EV_DONE 2

// Reset values
`define OVM_RST_MASK 3'h0
`define OVM_RST_DATA 32'h0000_0000

`endif

// [ovm_muldiv_core.v]
`timescale 1ns/10ps
`include "ovm_consts.vh"

// Iterative unsigned multiplier and fraction divider, one bit per cycle
module ovm_muldiv_core #(
    parameter W = 48
) (
    input wire clk,                 // System clock
    input wire rst,                 // Synchronous reset
    input wire start,               // Begin an operation
    input wire op_div,              // 1 divide, 0 multiply
    input wire [W-1:0] mag_x,       // Multiplicand or dividend magnitude
    input wire [W-1:0] mag_y,       // Multiplier or divisor magnitude
    output reg done_q,              // Result valid pulse
    output reg [2*W-1:0] prod_q,    // Product magnitude
    output reg [W-1:0] quo_q,       // Quotient magnitude
    output reg [W:0] rem_q          // Remainder magnitude
);
    reg busy_q;
    reg div_q;
    reg [7:0] cnt_q;
    reg [W-1:0] x_q;
    reg [W-1:0] y_q;
    reg [W:0] trial;
    reg take;

    // First divide step compares unshifted: dividend never exceeds divisor
    always @* begin
        trial = (cnt_q == 8'h00) ? rem_q : {rem_q[W-1:0], 1'b0};
        take = trial >= {1'b0, y_q};
    end

    // Shift-add multiply and restoring divide share one step counter
    always @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            div_q <= 1'b0;
            cnt_q <= 8'h00;
            x_q <= {W{1'b0}};
            y_q <= {W{1'b0}};
            done_q <= 1'b0;
            prod_q <= {(2*W){1'b0}};
            quo_q <= {W{1'b0}};
            rem_q <= {(W+1){1'b0}};
        end else begin
            done_q <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                div_q <= op_div;
                cnt_q <= 8'h00;
                x_q <= mag_x;
                y_q <= mag_y;
                prod_q <= {(2*W){1'b0}};
                quo_q <= {W{1'b0}};
                rem_q <= {1'b0, mag_x};
            end else if (busy_q) begin
                if (div_q) begin
                    rem_q <= take ? trial - {1'b0, y_q} : trial;
                    quo_q <= {quo_q[W-2:0], take};
                end else begin
                    prod_q <= {prod_q[2*W-2:0], 1'b0} +
                        (y_q[W-1] ? {{W{1'b0}}, x_q} : {(2*W){1'b0}});
                    y_q <= {y_q[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q + 8'h01;
                // Compared at 32 bits so the width parameter is not cut
                if ({24'h00, cnt_q} == W - 1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule

// [ovm_overflow_unit_asserts.sv]
`timescale 1ns/10ps
`include "ovm_consts.vh"
module ovm_overflow_unit_asserts (
    input wire clk, // System clock
    input wire rst, // Synchronous reset
    input wire wb_cyc_i, // Bus cycle
    input wire wb_stb_i, // Bus strobe
    input wire wb_we_i, // Write enable
    input wire [7:0] wb_adr_i, // Byte address
    input wire [3:0] wb_sel_i, // Byte lanes
    input wire [31:0] wb_dat_i, // Write data
    input wire [31:0] wb_dat_o, // Read data
    input wire wb_ack_o, // Acknowledge
    input wire ovf_stop_sw, // Stop switch
    input wire ovf_lamp_o, // Indicator lamp
    input wire halt_o, // Stopped
    input wire irq_o // Interrupt
);
// Accepted requests and decoded command writes
wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire cmd_tk = tk && wb_we_i && wb_adr_i == `OVM_ADR_CMD && wb_sel_i[0];
wire [3:0] opc = wb_dat_i[3:0];
wire res_tk = cmd_tk && opc == `OVM_OP_RESUME;
wire jmp_tk = cmd_tk && !halt_o &&
    (opc == `OVM_OP_JOVF || opc == `OVM_OP_JNOVF);

default clocking cb @(posedge clk);
endclocking
default disable iff (rst);

// One acknowledge for each accepted request
a_ack_follows_req: assert property (tk |=> wb_ack_o)
    else $error("No acknowledge after request");
a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held too long");
a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(tk))
    else $error("Acknowledge without request");
// Addresses past the end of the map read back as zero
a_unmapped_reads_zero: assert property (
    tk && !wb_we_i && wb_adr_i >= 8'h28 |=> wb_dat_o == 32'h0)
    else $error("Unmapped read not zero");
// Lamp checked two edges on; it changes on the same edge as the flag
a_inhibit_clears_lamp: assert property (
    cmd_tk && opc == `OVM_OP_INHIBIT && !halt_o && !ovf_stop_sw
    |-> ##2 !ovf_lamp_o) else $error("Lamp lit after inhibit");
a_halt_lamp_lit: assert property ($rose(halt_o) |-> ovf_lamp_o)
    else $error("Halt without lit lamp");
a_halt_needs_resume: assert property (
    $fell(halt_o) |-> $past(res_tk) || $past(res_tk, 2))
    else $error("Halt released without resume");
a_jump_never_halts: assert property (
    jmp_tk |=> !$rose(halt_o) ##1 !$rose(halt_o))
    else $error("Halt on overflow jump");
a_jump_keeps_lamp: assert property (
    jmp_tk |-> ##2 ovf_lamp_o == $past(ovf_lamp_o, 2))
    else $error("Jump changed the lamp");
// Main scenarios reached
c_jump: cover property (jmp_tk);
c_halt: cover property ($rose(halt_o));
c_resume: cover property ($fell(halt_o));
c_irq: cover property ($rose(irq_o));
endmodule

bind ovm_overflow_unit ovm_overflow_unit_asserts ovm_overflow_unit_asserts_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ovf_stop_sw(ovf_stop_sw), .ovf_lamp_o(ovf_lamp_o),
    .halt_o(halt_o), .irq_o(irq_o));

// [ovm_overflow_unit_tb.sv]
`timescale 1ns/10ps
`include "ovm_consts.vh"
module ovm_overflow_unit_tb;
localparam [47:0] ZR = 48'h0;
localparam [47:0] ONE = 48'h1;
localparam [47:0] HF = 48'h400000000000;
localparam [47:0] NHF = 48'hc00000000000;
localparam [47:0] QT = 48'h200000000000;
localparam [47:0] NQT = 48'he00000000000;
localparam [47:0] TQ = 48'h600000000000;
localparam [47:0] M1 = 48'h800000000000;
localparam [47:0] ALL = 48'hffffffffffff;
reg clk = 1'b0;
reg rst = 1'b1;
reg cyc = 1'b0;
reg stb = 1'b0;
reg we = 1'b0;
reg [7:0] adr = 8'h0;
reg [3:0] sel = 4'h0;
reg [31:0] wdat = 32'h0;
reg sw = 1'b0;
wire [31:0] rdat;
wire ack;
wire lamp;
wire halt;
wire irq;
integer mismatches = 0;
integer samples_checked = 0;
integer i;
reg [31:0] r;
reg [47:0] v;

ovm_overflow_unit ovm_overflow_unit_inst (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ovf_stop_sw(sw), .ovf_lamp_o(lamp), .halt_o(halt), .irq_o(irq));

// 50 MHz clock
initial begin
    forever #10 clk = ~clk;
end

task test_done;
    begin
        $display("Checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    end
endtask

task chk(input [71:0] nm, input [47:0] e, input [47:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
        end
    end
endtask

// Classic cycle; held until ack is sampled, bounded wait
task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
endtask

// 48-bit words travel as low 32 then high 16
task ld48(input [7:0] a, input [47:0] d);
    begin
        wb(1'b1, a, d[31:0]);
        wb(1'b1, a + 8'h4, {16'h0, d[47:32]});
    end
endtask

task rd48(input [7:0] a);
    begin
        wb(1'b0, a, 32'h0);
        v[31:0] = r;
        wb(1'b0, a + 8'h4, 32'h0);
        v[47:32] = r[15:0];
    end
endtask

// Issue an instruction, then poll until not busy; r keeps status
task op(input [3:0] c);
    integer n;
    begin
        wb(1'b1, `OVM_ADR_CMD, {28'h0, c});
        n = 0;
        r = 32'h10;
        while (r[`OVM_ST_BUSY] !== 1'b0 && n < 100) begin
            wb(1'b0, `OVM_ADR_STATUS, 32'h0);
            n = n + 1;
        end
        if (n == 100) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
endtask

task sb(input integer b, input e);
    begin
        chk("status", {47'h0, e}, {47'h0, r[b]});
    end
endtask

// Zero masks skip a register
task go(input [3:0] c, input [47:0] ea, input [47:0] am,
        input [47:0] eq, input [47:0] qm, input ei);
    begin
        op(c);
        chk("indicator", {47'h0, ei}, {47'h0, r[`OVM_ST_IND]});
        chk("lamp", {47'h0, ei}, {47'h0, lamp});
        if (am != ZR) begin
            rd48(`OVM_ADR_A_LO);
            chk("acc", ea, v & am);
        end
        if (qm != ZR) begin
            rd48(`OVM_ADR_Q_LO);
            chk("quot", eq, v & qm);
        end
    end
endtask

task run(input [3:0] c, input [47:0] a, input [47:0] d, input [47:0] ea,
         input [47:0] am, input [47:0] eq, input [47:0] qm, input ei);
    begin
        ld48(`OVM_ADR_A_LO, a);
        ld48(`OVM_ADR_D_LO, d);
        go(c, ea, am, eq, qm, ei);
    end
endtask

// Main sequence
initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 11; i = i + 1) begin
        wb(1'b0, {i[5:0], 2'b00}, 32'h0);
        chk("reset", ZR, {16'h0, r});
    end
    run(`OVM_OP_ADD, HF, HF, M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_ADD, M1, ALL, ~M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_ADD, NHF, NHF, M1, ALL, ZR, ZR, 1'b0);
    run(`OVM_OP_SUB, M1, ONE, ~M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_SUB, ZR, M1, M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_SHR, M1, ZR, NHF, ALL, ZR, ZR, 1'b0);
    run(`OVM_OP_MUL, HF, NHF, M1, M1, M1, M1, 1'b0);
    run(`OVM_OP_MUL, NHF, NHF, QT, ALL, ZR, ALL, 1'b0);
    run(`OVM_OP_MUL, M1, M1, M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_MUL, HF, ONE, ZR, ALL, HF, ALL, 1'b0);
    run(`OVM_OP_MULR, HF, ONE, ONE, ALL, HF, ALL, 1'b0);
    run(`OVM_OP_DIV, TQ, HF, TQ >> 1, ALL, ZR, ALL, 1'b1);
    go(`OVM_OP_DIV, ZR, ALL, TQ, ALL, 1'b0);
    run(`OVM_OP_DIV, NQT, HF, NHF, ALL, NHF, ALL, 1'b0);
    run(`OVM_OP_DIV, NQT, NHF, NHF, ALL, ~NHF, ALL, 1'b0);
    run(`OVM_OP_DIV, QT, NHF, ZR, ALL, ~HF, ALL, 1'b0);
    run(`OVM_OP_DIV, QT, TQ, ZR, M1, 48'h2aaaaaaaaaaa, ALL, 1'b0);
    run(`OVM_OP_DIV, NQT, TQ, M1, M1, 48'hd55555555555, ALL, 1'b0);
    go(`OVM_OP_INHIBIT, ZR, ZR, ZR, ZR, 1'b0);
    sb(`OVM_ST_INH, 1'b1);
    run(`OVM_OP_ADD, HF, HF, M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_ADD, ZR, ONE, ONE, ALL, ZR, ZR, 1'b1);
    go(`OVM_OP_JNOVF, ZR, ZR, ZR, ZR, 1'b1);
    sb(`OVM_ST_JUMP, 1'b0);
    go(`OVM_OP_JOVF, ZR, ZR, ZR, ZR, 1'b1);
    sb(`OVM_ST_JUMP, 1'b1);
    go(`OVM_OP_RELEASE, ZR, ZR, ZR, ZR, 1'b1);
    sb(`OVM_ST_INH, 1'b0);
    run(`OVM_OP_ADD, ZR, ONE, ONE, ALL, ZR, ZR, 1'b0);
    go(`OVM_OP_JOVF, ZR, ZR, ZR, ZR, 1'b0);
    sb(`OVM_ST_JUMP, 1'b0);
    go(`OVM_OP_JNOVF, ZR, ZR, ZR, ZR, 1'b0);
    sb(`OVM_ST_JUMP, 1'b1);
    // Stop switch on; only the halt event may interrupt
    wb(1'b1, `OVM_ADR_INT_MASK, 32'h2);
    @(posedge clk);
    sw <= 1'b1;
    run(`OVM_OP_ADD, HF, HF, M1, ALL, ZR, ZR, 1'b1);
    go(`OVM_OP_JOVF, ZR, ZR, ZR, ZR, 1'b1);
    sb(`OVM_ST_JUMP, 1'b1);
    chk("halt", ZR, {47'h0, halt});
    chk("irq", ZR, {47'h0, irq});
    run(`OVM_OP_ADD, HF, HF, M1, ALL, ZR, ZR, 1'b1);
    run(`OVM_OP_ADD, ZR, ONE, ZR, ALL, ZR, ZR, 1'b1);
    // The accumulator read left r holding data, so fetch status again
    wb(1'b0, `OVM_ADR_STATUS, 32'h0);
    sb(`OVM_ST_HALT, 1'b1);
    chk("halt", ONE, {47'h0, halt});
    chk("irq", ONE, {47'h0, irq});
    // Loads are refused while stopped
    ld48(`OVM_ADR_A_LO, HF);
    rd48(`OVM_ADR_A_LO);
    chk("acc", ZR, v);
    wb(1'b1, `OVM_ADR_INT_STAT, 32'h2);
    chk("irq", ZR, {47'h0, irq});
    go(`OVM_OP_RESUME, ZR, ZR, ZR, ZR, 1'b1);
    chk("halt", ZR, {47'h0, halt});
    sw <= 1'b0;
    test_done;
end
endmodule
